/* File: verilog/cell_result_pkg.sv */
// constants for the cell 6..9 voltage result register bank
// assumes a 32-bit apb slave; offsets are word indices, byte = 4 * index
package cell_result_pkg;
    localparam int CODE_W = 14;
    localparam int REG_W = 16;
    localparam int CELL_COUNT = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // code field inside a result register
    localparam int CODE_LSB = 2;
    localparam int CODE_MSB = 15;
    // full-scale input span of one code range, in millivolts
    localparam int FULL_SCALE_MV = 5000;
    // word indices of the result registers, cell 6 first
    localparam logic [7:0] CELL_SIX_CODE_RESULT_IDX = 8'h4c;
    localparam logic [7:0] CELL_SEVEN_CODE_RESULT_IDX = 8'h4d;
    localparam logic [7:0] CELL_EIGHT_CODE_RESULT_IDX = 8'h4e;
    localparam logic [7:0] CELL_NINE_CODE_RESULT_IDX = 8'h4f;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // control register: enables in [3:0], readback select in [8]
    localparam logic [7:0] CTRL_IDX = 8'h40;
    localparam int CTRL_ENABLE_LSB = 0;
    localparam int CTRL_SELECT_BIT = 8;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    localparam logic SELECT_RESET = 1'b0;

    // byte address of a word index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {{(ADDR_W-10){1'b0}}, idx, 2'b00};
    endfunction : byte_addr

    // code into register layout: code[13:6] -> 15:8, code[5:0] -> 7:2
    function automatic logic [REG_W-1:0] place_code(
        input logic [CODE_W-1:0] code);
        place_code = {code, 2'b00};
    endfunction : place_code
endpackage : cell_result_pkg

/* File: verilog/cell_result_slot.sv */
// one cell's stored arithmetic and filter results with readback select
// assumes capture is a one-cycle pulse from the scan completion logic
`timescale 1ns/10ps
module cell_result_slot
    import cell_result_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // measurement side
    input wire logic capture,
    input wire logic [CODE_W-1:0] alu_in,
    input wire logic [CODE_W-1:0] iir_in,
    input wire logic use_iir,
    // readback
    output logic [REG_W-1:0] result
);
    logic [REG_W-1:0] alu_q;
    logic [REG_W-1:0] iir_q;

    // only the measurement logic writes here; the bus has no path in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alu_q <= RESULT_RESET;
            iir_q <= RESULT_RESET;
        end else if (capture) begin
            alu_q <= place_code(alu_in);
            iir_q <= place_code(iir_in);
        end
    end

    // both values are kept so the select can change without a rescan
    assign result = use_iir ? iir_q : alu_q;

    capture_last_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        capture |=> alu_q[CODE_MSB:CODE_LSB] == $past(alu_in)
            && iir_q[CODE_MSB:CODE_LSB] == $past(iir_in))
        else $error("capture did not store latest codes");
    hold_value_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !capture |=> $stable(alu_q) && $stable(iir_q))
        else $error("stored result changed without capture");
endmodule : cell_result_slot

/* File: verilog/cell_result_regs.sv */
// apb register bank holding the voltage results of cells 6 to 9
// assumes a scan engine pulsing scan_done with a mask of measured cells
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module cell_result_regs
    import cell_result_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // scan engine
    input wire logic scan_done,
    input wire logic [CELL_COUNT-1:0] cell_scanned,
    input wire logic [CELL_COUNT*CODE_W-1:0] alu_code,
    input wire logic [CELL_COUNT*CODE_W-1:0] iir_code,
    // control outputs
    output logic [CELL_COUNT-1:0] cell_measure_enable,
    output logic filter_readback_select
);
    logic [REG_W-1:0] cell_result_value [CELL_COUNT];
    logic [CELL_COUNT-1:0] capture;
    logic setup_rd;
    logic access;
    logic hit_ctrl;
    logic [CELL_COUNT-1:0] hit_cell;
    logic mapped;
    logic [DATA_W-1:0] next_prdata;

    // address decode, shared by read and write
    always_comb begin
        hit_ctrl = paddr == byte_addr(CTRL_IDX);
        hit_cell[0] = paddr == byte_addr(CELL_SIX_CODE_RESULT_IDX);
        hit_cell[1] = paddr == byte_addr(CELL_SEVEN_CODE_RESULT_IDX);
        hit_cell[2] = paddr == byte_addr(CELL_EIGHT_CODE_RESULT_IDX);
        hit_cell[3] = paddr == byte_addr(CELL_NINE_CODE_RESULT_IDX);
        mapped = hit_ctrl || (|hit_cell);
    end

    assign access = psel && penable;
    assign setup_rd = psel && !penable && !pwrite;
    // zero wait states: read data is fetched in the setup cycle
    assign pready = 1'b1;
    // unmapped addresses error; writes to result words succeed silently
    assign pslverr = access && !mapped;

    // control register; byte lane 0 carries enables, lane 1 the select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_measure_enable <= ENABLE_RESET;
        end else if (access && pwrite && hit_ctrl && pstrb[0]) begin
            cell_measure_enable <=
                pwdata[CTRL_ENABLE_LSB +: CELL_COUNT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_readback_select <= SELECT_RESET;
        end else if (access && pwrite && hit_ctrl && pstrb[1]) begin
            filter_readback_select <= pwdata[CTRL_SELECT_BIT];
        end
    end

    // a cell left out of the scan captures nothing, so its old data
    // stays; an enabled but skipped cell is treated the same way
    always_comb begin
        for (int i = 0; i < CELL_COUNT; i++) begin
            capture[i] = scan_done && cell_scanned[i];
        end
    end

    // each code counts in steps of FULL_SCALE_MV / 2**CODE_W
    for (genvar g = 0; g < CELL_COUNT; g++) begin : g_cell
        cell_result_slot u_slot (
            .pclk(pclk),
            .presetn(presetn),
            .capture(capture[g]),
            .alu_in(alu_code[g*CODE_W +: CODE_W]),
            .iir_in(iir_code[g*CODE_W +: CODE_W]),
            .use_iir(filter_readback_select),
            .result(cell_result_value[g])
        );

        // a skipped, disabled cell keeps what it had, whatever its neighbours
        skip_cell_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            !cell_scanned[g] && !cell_measure_enable[g]
            && !(access && pwrite && hit_ctrl)
            |=> $stable(cell_result_value[g]))
            else $error("skipped cell result moved");

        read_cell_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            setup_rd && hit_cell[g]
            |=> prdata == {16'h0000, $past(cell_result_value[g])})
            else $error("result read not the stored value");
    end

    // read mux; bits 1:0 of a result word are forced low
    always_comb begin
        next_prdata = '0;
        if (hit_ctrl) begin
            next_prdata[CTRL_ENABLE_LSB +: CELL_COUNT] = cell_measure_enable;
            next_prdata[CTRL_SELECT_BIT] = filter_readback_select;
        end
        for (int i = 0; i < CELL_COUNT; i++) begin
            if (hit_cell[i]) begin
                next_prdata[REG_W-1:0] =
                    {cell_result_value[i][CODE_MSB:CODE_LSB], 2'b00};
            end
        end
    end

    // registered read data, stable through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_rd) begin
            prdata <= next_prdata;
        end
    end

    // bus-side and capture checks; each watches what this block drives
    low_bits_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && !pwrite && (|hit_cell) |-> prdata[1:0] == 2'b00)
        else $error("result low bits not zero");

    code_place_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_rd && hit_cell[0] && !scan_done ##1 !scan_done
        |-> prdata[15:2] == cell_result_value[0][15:2]
            && prdata[31:16] == 16'h0000)
        else $error("cell code not in bits 15:2");

    ro_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_cell[1] && !scan_done
        |=> $stable(cell_result_value[1]))
        else $error("software write changed a result");

    // a control write in the same cycle may flip the readback select
    skip_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        scan_done && !cell_scanned[1] && !cell_measure_enable[1]
        && !(access && pwrite && hit_ctrl)
        |=> $stable(cell_result_value[1]))
        else $error("skipped cell data changed");

    latest_value_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        scan_done && cell_scanned[3] && !filter_readback_select
        ##1 !access && !filter_readback_select
        |-> cell_result_value[3][15:2] == $past(alu_code[55:42]))
        else $error("cell 9 lost its latest value");

    select_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_ctrl && pstrb[1]
        |=> filter_readback_select == $past(pwdata[CTRL_SELECT_BIT]))
        else $error("readback select not taken");

    // back-to-back control writes are legal, so hold is checked per cycle
    select_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit_ctrl && pstrb[1])
        |=> $stable(filter_readback_select))
        else $error("readback select moved without a write");

    unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && !mapped |-> pslverr && pready ##1 !pslverr || access)
        else $error("unmapped access not flagged");

    scale_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        scan_done && cell_scanned[0] && alu_code[13:0] == 14'h3fff
        && !filter_readback_select ##1 !filter_readback_select
        |-> cell_result_value[0] == 16'hfffc)
        else $error("full-scale code not at top of range");

    enable_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_ctrl && pstrb[0]
        |=> cell_measure_enable == $past(pwdata[CTRL_ENABLE_LSB +: 4]))
        else $error("measure enables not taken");

    // a cleared strobe leaves its byte lane alone
    enable_lane_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit_ctrl && pstrb[0])
        |=> $stable(cell_measure_enable))
        else $error("measure enables moved without a write");

    mapped_ok_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && (|hit_cell) |-> !pslverr && pready)
        else $error("result access flagged an error");

    no_idle_err_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !access |-> !pslverr)
        else $error("error flag outside an access phase");

    unmapped_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_rd && !mapped |=> prdata == '0)
        else $error("unmapped read returned data");

    // read data must not move while the master may still sample it
    prdata_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !setup_rd |=> $stable(prdata))
        else $error("read data changed outside a setup cycle");
endmodule : cell_result_regs

/* File: verif/tb_top.sv */
// bench for the cell 6..9 result register bank, driven over apb
// assumes the package constants; waits for pready, never assumes latency
`timescale 1ns/10ps
module tb_top;
    import cell_result_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, scan_done, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb, cell_scanned, cell_measure_enable;
    logic [CELL_COUNT*CODE_W-1:0] alu_code, iir_code;
    logic filter_readback_select, er, sel;
    logic [CODE_W-1:0] ma[4], mf[4];
    logic [7:0] ci[4];
    int failures = 0;
    int total_checks = 0;

    cell_result_regs cell_result_regs_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scan_done(scan_done),
        .cell_scanned(cell_scanned), .alu_code(alu_code),
        .iir_code(iir_code), .cell_measure_enable(cell_measure_enable),
        .filter_readback_select(filter_readback_select));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one full transfer; an edge passes first so psel is never set twice
    task automatic apb(input logic [7:0] i, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        pwdata <= d;
        paddr <= {2'b00, i, 2'b00};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            failures++;
            $display("[ERR] pready expected 1 seen %b", pready);
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // every result word against the model, through the readback select
    task automatic rd_all();
        for (int k = 0; k < 4; k++) begin
            apb(ci[k], 1'b0, 32'h0);
            chk("result", {16'h0, sel ? mf[k] : ma[k], 2'b00},
                rd);
            chk("pslverr", 32'h0, {31'h0, er});
        end
    endtask : rd_all

    // new codes go to every cell; only scanned cells may take them
    task automatic scan(input logic [3:0] m, input logic [13:0] s);
        logic [CELL_COUNT*CODE_W-1:0] a, f;
        for (int k = 0; k < 4; k++) begin
            a[k*14 +: 14] = s ^ {k[1:0], 12'h123 * k[1:0]};
            f[k*14 +: 14] = ~a[k*14 +: 14];
            if (m[k]) begin
                ma[k] = a[k*14 +: 14];
                mf[k] = f[k*14 +: 14];
            end
        end
        @(posedge pclk);
        scan_done <= 1'b1;
        cell_scanned <= m;
        alu_code <= a;
        iir_code <= f;
        @(posedge pclk);
        scan_done <= 1'b0;
    endtask : scan

    task automatic t_reset();
        rd_all();
        apb(CTRL_IDX, 1'b0, 32'h0);
        chk("ctrl", 32'h0, rd);
        chk("enable", 32'h0, {28'h0, cell_measure_enable});
    endtask : t_reset

    // cell 6 gets the full-scale code 3fff, its filter value 0000
    task automatic t_capture();
        scan(4'hf, 14'h3fff);
        rd_all();
    endtask : t_capture

    task automatic t_select();
        apb(CTRL_IDX, 1'b1, 32'h105);
        sel = 1'b1;
        // the control flops load at the edge apb returns on
        @(negedge pclk);
        chk("enable", 32'h5, {28'h0, cell_measure_enable});
        chk("select", 32'h1, {31'h0, filter_readback_select});
        rd_all();
    endtask : t_select

    task automatic t_skip();
        pstrb <= 4'h1;
        apb(CTRL_IDX, 1'b1, 32'h000);
        pstrb <= 4'h2;
        @(negedge pclk);
        chk("select", 32'h1, {31'h0, filter_readback_select});
        apb(CTRL_IDX, 1'b1, 32'h10f);
        pstrb <= 4'hf;
        @(negedge pclk);
        chk("enable", 32'h0, {28'h0, cell_measure_enable});
        scan(4'b0101, 14'h0a5c);
        rd_all();
        apb(CTRL_IDX, 1'b1, 32'h0);
        sel = 1'b0;
        rd_all();
    endtask : t_skip

    task automatic t_readonly();
        for (int k = 0; k < 4; k++) begin
            apb(ci[k], 1'b1, 32'hffffffff);
            chk("pslverr", 32'h0, {31'h0, er});
        end
        rd_all();
    endtask : t_readonly

    // an unmapped word answers with an error and zero data
    task automatic t_unmapped();
        apb(8'h80, 1'b0, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        chk("prdata", 32'h0, rd);
    endtask : t_unmapped

    initial begin
        ci = '{CELL_SIX_CODE_RESULT_IDX, CELL_SEVEN_CODE_RESULT_IDX, CELL_EIGHT_CODE_RESULT_IDX,
               CELL_NINE_CODE_RESULT_IDX};
        presetn = 1'b0;
        {psel, penable, pwrite, scan_done, sel} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        cell_scanned = '0;
        alu_code = '0;
        iir_code = '0;
        for (int k = 0; k < 4; k++) begin
            ma[k] = '0;
            mf[k] = '0;
        end
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_capture();
        t_select();
        t_skip();
        t_readonly();
        t_unmapped();
        tally_and_finish();
    end
endmodule : tb_top
